/* inc/acmc_pkg.sv */
// shared constants for the auxiliary converter measure control
package acmc_pkg;
	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam logic [7:0]  CTRL_ONE_ADDR     = 8'h90;
	localparam logic [7:0]  CTRL_TWO_ADDR     = 8'h91;
	localparam logic [15:0] CTRL_ONE_RESET    = 16'h0000;
	localparam logic [15:0] CTRL_TWO_RESET    = 16'h0000;
	localparam logic [15:0] CTRL_ONE_RW_MASK  = 16'hD0FF;
	localparam logic [15:0] CTRL_TWO_RW_MASK  = 16'h0701;
	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int ENA_BIT      = 15;
	localparam int CTC_BIT      = 14;
	localparam int POLL_BIT     = 13;
	localparam int HIB_BIT      = 12;
	localparam int SEL_LSB      = 0;
	localparam int SEL_W        = 8;
	localparam int RATE_LSB     = 8;
	localparam int RATE_W       = 3;
	localparam int WAIT_BIT     = 0;
	localparam int SRC_W        = 3;
	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam int CLK_PERIOD_PS      = 5000;
	localparam longint BASE_TICK_PS   = 64'd3906250000;
	localparam int BASE_TICK_CYCLES   = int'(BASE_TICK_PS / CLK_PERIOD_PS);
	localparam int SLOWEST_TICKS      = 256;
	localparam int TICK_CNT_W         = 9;
	localparam int RATE_RESET         = 0;
endpackage

/* inc/acmc_seq_if.sv */
// handshake between the control word and the measurement sequencer
interface acmc_seq_if;
	logic                          start;
	logic                          abort;
	logic [acmc_pkg::SEL_W-1:0]    sel_mask;
	logic                          holdoff;
	logic                          conv_done;
	logic                          conv_start;
	logic [acmc_pkg::SRC_W-1:0]    conv_src;
	logic                          busy;
	logic                          set_done;
	modport ctrl (
		output start, abort, sel_mask, holdoff, conv_done,
		input  conv_start, conv_src, busy, set_done
	);
	modport seq (
		input  start, abort, sel_mask, holdoff, conv_done,
		output conv_start, conv_src, busy, set_done
	);
endinterface

/* logic/acmc_sequencer.sv */
// steps through the selected sources of one measurement set
module acmc_sequencer (
	input  wire logic   clk,     // system clock
	input  wire logic   rst_n,   // synchronised reset, active low
	acmc_seq_if.seq     sq       // control handshake
);
	typedef enum logic [2:0] {
		SQ_IDLE = 3'b001,
		SQ_SCAN = 3'b010,
		SQ_WAIT = 3'b100
	} acmc_sq_state_type;

	acmc_sq_state_type              state_ff;
	acmc_sq_state_type              nxt_state;
	logic [acmc_pkg::SEL_W-1:0]     left_ff;
	logic [acmc_pkg::SEL_W-1:0]     nxt_left;
	logic                           start_ff;
	logic [acmc_pkg::SRC_W-1:0]     src_ff;
	logic                           done_ff;
	logic [acmc_pkg::SRC_W-1:0]     low_idx;
	logic                           issue;
	logic                           finish;

	// lowest pending source is measured first
	function automatic logic [acmc_pkg::SRC_W-1:0] low_set(input logic [acmc_pkg::SEL_W-1:0] m);
		logic [acmc_pkg::SRC_W-1:0] r;
		r = '0;
		for (int i = acmc_pkg::SEL_W - 1; i >= 0; i--) begin
			if (m[i]) begin
				r = acmc_pkg::SRC_W'(i);
			end
		end
		return r;
	endfunction

	assign low_idx = low_set(left_ff);
	assign issue   = (state_ff == SQ_SCAN) && (left_ff != '0) && !sq.holdoff && !sq.abort;
	assign finish  = (state_ff == SQ_SCAN) && (left_ff == '0) && !sq.abort;

	always_comb begin
		nxt_state = state_ff;
		nxt_left  = left_ff;
		unique case (state_ff)
			SQ_IDLE: begin
				if (sq.start && !sq.abort) begin
					nxt_state = SQ_SCAN;
					nxt_left  = sq.sel_mask;
				end
			end
			SQ_SCAN: begin
				if (finish) begin
					nxt_state = SQ_IDLE;
				end else if (issue) begin
					nxt_state = SQ_WAIT;
					nxt_left  = left_ff & ~(acmc_pkg::SEL_W'(1) << low_idx);
				end
			end
			SQ_WAIT: begin
				if (sq.conv_done) begin
					nxt_state = SQ_SCAN;
				end
			end
			default: begin
				nxt_state = SQ_IDLE;
			end
		endcase
		if (sq.abort) begin
			nxt_state = SQ_IDLE;
			nxt_left  = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= SQ_IDLE;
			left_ff  <= '0;
			start_ff <= 1'b0;
			src_ff   <= '0;
			done_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			left_ff  <= nxt_left;
			start_ff <= issue;
			src_ff   <= issue ? low_idx : src_ff;
			done_ff  <= finish;
		end
	end

	assign sq.conv_start = start_ff;
	assign sq.conv_src   = src_ff;
	assign sq.set_done   = done_ff;
	assign sq.busy       = (state_ff != SQ_IDLE);
endmodule

/* logic/acmc_top.sv */
// control word and scheduling for the auxiliary measure converter
module acmc_top #(
	parameter int BASE_TICK_CYC = acmc_pkg::BASE_TICK_CYCLES  // cycles per 256 Hz tick
) (
	input  wire logic        CLK,          // 200 MHz clock
	input  wire logic        RESET_N,      // asynchronous reset, active low
	input  wire logic        SM_RESET,     // state machine reset pulse
	input  wire logic        HIBERNATE,    // device is in hibernate, level
	input  wire logic [7:0]  REG_ADDR,     // register address
	input  wire logic [15:0] REG_WDATA,    // register write data
	input  wire logic        REG_WR,       // write strobe
	input  wire logic        REG_RD,       // read strobe
	input  wire logic        CONV_DONE,    // conversion finished pulse
	input  wire logic        RESULT_READ,  // result was read pulse
	output logic [15:0]      REG_RDATA,    // read data, one cycle after strobe
	output logic             CONV_ENABLE,  // converter powered
	output logic             CONV_START,   // start one conversion pulse
	output logic [2:0]       CONV_SRC,     // source of the conversion
	output logic             SET_BUSY      // measurement set running
);
	// -----------------------------------------------------------------
	// reset release
	// -----------------------------------------------------------------
	logic [1:0] rst_sync_ff;
	logic       rst_n;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_ff[1];

	// -----------------------------------------------------------------
	// control words
	// -----------------------------------------------------------------
	logic [15:0] ctrl_one_ff;
	logic [15:0] nxt_ctrl_one;
	logic [15:0] ctrl_two_ff;
	logic [15:0] nxt_ctrl_two;
	logic        wr_one;
	logic        wr_two;
	logic        rd_one;
	logic        rd_two;
	logic        poll_set;
	logic        poll_clr;
	logic        converter_enable;
	logic        continuous_mode_select;
	logic        poll_trigger;
	logic        hibernate_disable_select;
	logic [7:0]  source_mask;
	logic [2:0]  continuous_rate_code;
	logic        result_read_holdoff;

	assign wr_one = REG_WR && (REG_ADDR == acmc_pkg::CTRL_ONE_ADDR);
	assign wr_two = REG_WR && (REG_ADDR == acmc_pkg::CTRL_TWO_ADDR);
	assign rd_one = REG_RD && (REG_ADDR == acmc_pkg::CTRL_ONE_ADDR);
	assign rd_two = REG_RD && (REG_ADDR == acmc_pkg::CTRL_TWO_ADDR);

	assign converter_enable         = ctrl_one_ff[acmc_pkg::ENA_BIT];
	assign continuous_mode_select   = ctrl_one_ff[acmc_pkg::CTC_BIT];
	assign poll_trigger             = ctrl_one_ff[acmc_pkg::POLL_BIT];
	assign hibernate_disable_select = ctrl_one_ff[acmc_pkg::HIB_BIT];
	assign source_mask              = ctrl_one_ff[acmc_pkg::SEL_LSB +: acmc_pkg::SEL_W];
	assign continuous_rate_code     = ctrl_two_ff[acmc_pkg::RATE_LSB +: acmc_pkg::RATE_W];
	assign result_read_holdoff      = ctrl_two_ff[acmc_pkg::WAIT_BIT];

	// poll request only counts when written as one in polling mode
	assign poll_set = wr_one && REG_WDATA[acmc_pkg::POLL_BIT]
		&& !REG_WDATA[acmc_pkg::CTC_BIT];

	// -----------------------------------------------------------------
	// effective enable and scheduling
	// -----------------------------------------------------------------
	logic run_ok;
	logic poll_go;
	logic cont_go;
	logic seq_busy;
	logic seq_done;
	logic poll_run_ff;

	// hibernate with the disable select forces the converter off
	assign run_ok = converter_enable && !(HIBERNATE && hibernate_disable_select);

	assign poll_go = run_ok && !continuous_mode_select && poll_trigger
		&& !seq_busy && !poll_run_ff;

	// trigger clears when its set ends, or when the converter stops or continuous mode is selected under it
	assign poll_clr = (poll_run_ff && seq_done)
		|| (poll_trigger && (!run_ok || continuous_mode_select));

	always_comb begin
		nxt_ctrl_one = ctrl_one_ff;
		if (wr_one) begin
			nxt_ctrl_one = (REG_WDATA & acmc_pkg::CTRL_ONE_RW_MASK)
				| (ctrl_one_ff & (16'h0001 << acmc_pkg::POLL_BIT));
			nxt_ctrl_one[acmc_pkg::POLL_BIT] = poll_trigger;
		end
		if (poll_clr) begin
			nxt_ctrl_one[acmc_pkg::POLL_BIT] = 1'b0;
		end
		if (poll_set) begin
			nxt_ctrl_one[acmc_pkg::POLL_BIT] = 1'b1;
		end
		if (SM_RESET) begin
			nxt_ctrl_one = acmc_pkg::CTRL_ONE_RESET;
		end
	end

	always_comb begin
		nxt_ctrl_two = ctrl_two_ff;
		if (wr_two) begin
			nxt_ctrl_two = REG_WDATA & acmc_pkg::CTRL_TWO_RW_MASK;
		end
		if (SM_RESET) begin
			nxt_ctrl_two = acmc_pkg::CTRL_TWO_RESET;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_one_ff <= acmc_pkg::CTRL_ONE_RESET;
			ctrl_two_ff <= acmc_pkg::CTRL_TWO_RESET;
		end else begin
			ctrl_one_ff <= nxt_ctrl_one;
			ctrl_two_ff <= nxt_ctrl_two;
		end
	end

	// -----------------------------------------------------------------
	// base tick divider, 256 Hz
	// -----------------------------------------------------------------
	logic [31:0] div_ff;
	logic        base_tick;

	assign base_tick = (div_ff == 32'(BASE_TICK_CYC - 1));

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			div_ff <= 32'h0000_0000;
		end else if (!run_ok || base_tick) begin
			div_ff <= 32'h0000_0000;
		end else begin
			div_ff <= div_ff + 32'h0000_0001;
		end
	end

	// -----------------------------------------------------------------
	// continuous rate
	// -----------------------------------------------------------------
	logic [acmc_pkg::TICK_CNT_W-1:0] tick_cnt_ff;
	logic [acmc_pkg::TICK_CNT_W-1:0] period_ticks;
	logic                            period_end;
	logic                            cont_active;

	// codes give 1 Hz, then 4 Hz doubling up to 256 Hz
	function automatic logic [acmc_pkg::TICK_CNT_W-1:0] ticks_of(input logic [2:0] code);
		logic [acmc_pkg::TICK_CNT_W-1:0] t;
		t = acmc_pkg::TICK_CNT_W'(acmc_pkg::SLOWEST_TICKS);
		if (code != 3'h0) begin
			t = t >> ({1'b0, code} + 4'h1);
		end
		return t;
	endfunction

	assign period_ticks = ticks_of(continuous_rate_code);
	assign cont_active  = run_ok && continuous_mode_select;
	assign period_end   = base_tick && (tick_cnt_ff >= period_ticks - 9'h001);

	// a period that ends while a set still runs is skipped
	assign cont_go = cont_active && period_end && !seq_busy;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_ff <= '0;
		end else if (!cont_active || period_end) begin
			tick_cnt_ff <= '0;
		end else if (base_tick) begin
			tick_cnt_ff <= tick_cnt_ff + 9'h001;
		end
	end

	// -----------------------------------------------------------------
	// result hold-off
	// -----------------------------------------------------------------
	logic unread_ff;

	// a new result wins over a read in the same cycle
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			unread_ff <= 1'b0;
		end else if (CONV_DONE) begin
			unread_ff <= 1'b1;
		end else if (RESULT_READ || SM_RESET) begin
			unread_ff <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// sequencer
	// -----------------------------------------------------------------
	acmc_seq_if sq_if ();

	assign sq_if.start     = poll_go || cont_go;
	assign sq_if.abort     = !run_ok || SM_RESET;
	assign sq_if.sel_mask  = source_mask;
	assign sq_if.holdoff   = result_read_holdoff && unread_ff;
	assign sq_if.conv_done = CONV_DONE;
	assign seq_busy        = sq_if.busy;
	assign seq_done        = sq_if.set_done;

	acmc_sequencer u_seq (
		.clk   (CLK),
		.rst_n (rst_n),
		.sq    (sq_if.seq)
	);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			poll_run_ff <= 1'b0;
		end else if (poll_go) begin
			poll_run_ff <= 1'b1;
		end else if (seq_done || sq_if.abort) begin
			poll_run_ff <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	logic [15:0] rd_mux;

	assign rd_mux = rd_one ? ctrl_one_ff : (rd_two ? ctrl_two_ff : 16'h0000);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			REG_RDATA   <= 16'h0000;
			CONV_ENABLE <= 1'b0;
			CONV_START  <= 1'b0;
			CONV_SRC    <= 3'h0;
			SET_BUSY    <= 1'b0;
		end else begin
			REG_RDATA   <= (REG_RD) ? rd_mux : REG_RDATA;
			CONV_ENABLE <= run_ok;
			CONV_START  <= sq_if.conv_start;
			CONV_SRC    <= sq_if.conv_src;
			SET_BUSY    <= seq_busy;
		end
	end
endmodule

/* tb/acmc_bench.sv */
// self-checking bench for the converter measure control
module acmc_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// signals
	// ----
	logic        clk = 1'b0, reset_n = 1'b0, sm_reset = 1'b0, hibernate = 1'b0;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, conv_done = 1'b0, result_read = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic        conv_enable, conv_start, set_busy;
	logic [2:0]  conv_src;
	logic [7:0]  mask;
	int          n_errors = 0, total_checks = 0;
	int          exp_q[$];
	always #2.5 clk = ~clk;
	acmc_top #(.BASE_TICK_CYC(4)) dut (
		.CLK(clk), .RESET_N(reset_n), .SM_RESET(sm_reset), .HIBERNATE(hibernate),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.CONV_DONE(conv_done), .RESULT_READ(result_read), .REG_RDATA(reg_rdata),
		.CONV_ENABLE(conv_enable), .CONV_START(conv_start), .CONV_SRC(conv_src), .SET_BUSY(set_busy)
	);
	// ----
	// tasks
	// ----
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		check(reg_rdata, exp);
	endtask
	task automatic pulse_done;
		@(posedge clk);
		conv_done <= 1'b1;
		@(posedge clk);
		conv_done <= 1'b0;
	endtask
	task automatic pulse_read;
		@(posedge clk);
		result_read <= 1'b1;
		@(posedge clk);
		result_read <= 1'b0;
	endtask
	// bounded wait for a start pulse or for the set to go idle
	task automatic wait_for(input bit want_start);
		int k;
		for (k = 0; k < 2100; k++) begin
			@(negedge clk);
			if ((want_start && conv_start === 1'b1) || (!want_start && set_busy === 1'b0)) break;
		end
		if (k == 2100) begin
			n_errors++;
			give_verdict();
		end
	endtask
	task automatic no_start(input int n);
		int hits = 0;
		repeat (n) begin
			@(negedge clk);
			if (conv_start !== 1'b0) hits++;
		end
		check(16'(hits), 16'h0000);
	endtask
	// model: expected sources of reps sets, lowest bit first
	task automatic run_set(input logic [7:0] m, input logic [15:0] word, input int reps);
		for (int j = 0; j < 8 * reps; j++) begin
			if (m[j % 8]) exp_q.push_back(j % 8);
		end
		while (exp_q.size() > 0) begin
			wait_for(1);
			@(negedge clk);
			check(16'(conv_src), 16'(exp_q.pop_front()));
			rd(8'h90, word);
			pulse_done();
		end
	endtask
	task automatic rate_check(input int code);
		time t0;
		int  p;
		int  e;
		p = (code == 0 ? 256 : 256 >> (code + 1)) * 4;
		e = p;
		// a period boundary inside the five busy cycles of a set is skipped
		while (e < 6) e += p;
		wr(8'h91, 16'(code << 8));
		wr(8'h90, 16'hC001);
		wait_for(1);
		t0 = $time;
		pulse_done();
		wait_for(1);
		check(16'(($time - t0) / 5), 16'(e));
		pulse_done();
		wr(8'h90, 16'h0000);
		wait_for(0);
	endtask
	task automatic hib_step(input logic lvl, input logic exp);
		@(posedge clk);
		hibernate <= lvl;
		repeat (3) @(negedge clk);
		check(16'(conv_enable), 16'(exp));
	endtask
	// ----
	// sequence
	// ----
	initial begin
		void'($urandom(32'hec0a));
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(8'h90, 16'h0000);
		rd(8'h91, 16'h0000);
		wr(8'h90, 16'h5CFF);
		rd(8'h90, 16'h50FF);
		wr(8'h91, 16'hFFFF);
		rd(8'h91, 16'h0701);
		wr(8'h92, 16'hFFFF);
		rd(8'h92, 16'h0000);
		wr(8'h91, 16'h0000);
		wr(8'h90, 16'h20FF);
		no_start(20);
		for (int i = 0; i < 6; i++) begin
			mask = (i == 0) ? 8'h00 : 8'($urandom());
			wr(8'h90, {8'hA0, mask});
			run_set(mask, {8'hA0, mask}, 1);
			if (mask == 8'h00) repeat (8) @(posedge clk);
			wait_for(0);
			rd(8'h90, {8'h80, mask});
		end
		wr(8'h91, 16'h0400);
		wr(8'h90, 16'hE081);
		run_set(8'h81, 16'hC081, 2);
		wr(8'h90, 16'h0000);
		wait_for(0);
		no_start(20);
		rate_check(0);
		rate_check(4);
		rate_check(7);
		wr(8'h90, 16'h9000);
		hib_step(1'b1, 1'b0);
		hib_step(1'b0, 1'b1);
		wr(8'h90, 16'h8000);
		hib_step(1'b1, 1'b1);
		hib_step(1'b0, 1'b1);
		pulse_read();
		wr(8'h91, 16'h0001);
		wr(8'h90, 16'hA003);
		wait_for(1);
		pulse_done();
		no_start(20);
		pulse_read();
		wait_for(1);
		pulse_done();
		wait_for(0);
		wr(8'h90, 16'h80FF);
		wr(8'h91, 16'h0701);
		@(posedge clk);
		sm_reset <= 1'b1;
		@(posedge clk);
		sm_reset <= 1'b0;
		rd(8'h90, 16'h0000);
		rd(8'h91, 16'h0000);
		give_verdict();
	end
endmodule

/* tb/acmc_properties.sv */
// port-level concurrent checks for the converter measure control
module acmc_properties (
	input wire logic        CLK,          // clock
	input wire logic        RESET_N,      // reset, active low
	input wire logic        SM_RESET,     // state machine reset
	input wire logic        HIBERNATE,    // hibernate level
	input wire logic [7:0]  REG_ADDR,     // register address
	input wire logic [15:0] REG_WDATA,    // write data
	input wire logic        REG_WR,       // write strobe
	input wire logic        REG_RD,       // read strobe
	input wire logic        CONV_DONE,    // conversion done
	input wire logic        RESULT_READ,  // result read
	input wire logic [15:0] REG_RDATA,    // read data
	input wire logic        CONV_ENABLE,  // converter on
	input wire logic        CONV_START,   // start pulse
	input wire logic [2:0]  CONV_SRC,     // converted source
	input wire logic        SET_BUSY      // set running
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// helpers
	// ----
	wire logic unmapped = (REG_ADDR != acmc_pkg::CTRL_ONE_ADDR) && (REG_ADDR != acmc_pkg::CTRL_TWO_ADDR);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	sequence s_off;
		!CONV_ENABLE [*4];
	endsequence
	// ----
	// properties
	// ----
	chk_no_start_off: assert property (s_off |-> !CONV_START)
		else $error("conversion started while converter off");
	chk_idle_when_off: assert property (s_off |-> !SET_BUSY)
		else $error("set busy while converter off");
	chk_start_single: assert property (CONV_START |=> !CONV_START)
		else $error("start pulse longer than one cycle");
	chk_start_in_set: assert property (CONV_START |-> SET_BUSY)
		else $error("start outside a measurement set");
	chk_done_gap: assert property (CONV_DONE |=> !CONV_START)
		else $error("start right after done");
	chk_src_steady: assert property ((!CONV_START && !$past(CONV_START)) |-> $stable(CONV_SRC))
		else $error("source changed without a start");
	chk_sm_clears: assert property (SM_RESET |-> ##[1:3] (!CONV_ENABLE && !SET_BUSY))
		else $error("state machine reset left converter active");
	chk_unmapped_zero: assert property ((REG_RD && unmapped) |=> REG_RDATA == 16'h0000)
		else $error("unmapped read not zero");
	chk_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
		else $error("read data changed without a read");
endmodule

bind acmc_top acmc_properties u_props (
	.CLK(CLK), .RESET_N(RESET_N), .SM_RESET(SM_RESET), .HIBERNATE(HIBERNATE),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.CONV_DONE(CONV_DONE), .RESULT_READ(RESULT_READ), .REG_RDATA(REG_RDATA),
	.CONV_ENABLE(CONV_ENABLE), .CONV_START(CONV_START), .CONV_SRC(CONV_SRC), .SET_BUSY(SET_BUSY)
);
